//--- rtl/pder_phy_diag_event_regs.sv
`timescale 1ns/1ps

module pder_phy_diag_event_regs
   import pder_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic          REF_CLK,           // Core clock, 50 MHz
   input  wire logic          SYS_RST,           // Async reset, high
   input  wire logic [AW-1:0] ADDR,              // Register offset
   input  wire logic [DW-1:0] WR_DATA,           // Write data
   input  wire logic          WR_EN,             // Write strobe
   input  wire logic          RD_EN,             // Read strobe
   output logic      [DW-1:0] RD_DATA,           // Read data, cycle after strobe
   output logic               CABLE_TEST_RUN,    // Test requested / in progress
   output logic      [1:0]    CABLE_TEST_PAIR,   // Pair under test
   input  wire logic          CABLE_TEST_DONE,   // Front end finished, pulse
   input  wire logic [1:0]    CABLE_TEST_FAULT,  // Fault code with done
   input  wire logic          LINK_1000_UP,      // Gigabit link state
   input  wire logic          LINK_100_UP,       // Fast link state
   input  wire logic          RX_SYM_ERR_FRAME,  // Frame with symbol error, pulse
   input  wire logic [7:0]    PHY_EVENT,         // Event pulses, jabber at bit 7
   output logic               PHY_IRQ,           // Per-port request
   output logic               XOVER_AUTO,        // Automatic crossover on
   output logic               XOVER_MDI          // Forced MDI when auto is off
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] ofs);
      hit = (a == AW'(ofs));
   endfunction

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      // Saturate rather than wrap so a stuck line cannot fake a small count
      sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
   endfunction

   logic wr_diag;
   logic wr_event;
   logic wr_xover;
   logic rd_cnt;
   logic rd_event;

   assign wr_diag  = WR_EN && hit(ADDR, OFS_CABLE_DIAG_CONTROL);
   assign wr_event = WR_EN && hit(ADDR, OFS_PHY_EVENT_CONTROL_STATUS);
   assign wr_xover = WR_EN && hit(ADDR, OFS_CROSSOVER_CONTROL);
   assign rd_cnt   = RD_EN && hit(ADDR, OFS_RX_SYMBOL_ERROR_COUNT);
   assign rd_event = RD_EN && hit(ADDR, OFS_PHY_EVENT_CONTROL_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Cable diagnostic

   logic       run_r;
   logic       run_nxt;
   logic [1:0] pair_r;
   logic [1:0] pair_nxt;
   logic [1:0] fault_r;
   logic [1:0] fault_nxt;
   logic       rsv14_r;
   logic       rsv14_nxt;
   logic [1:0] rsv_r;
   logic [1:0] rsv_nxt;

   always_comb begin
      run_nxt   = run_r;
      pair_nxt  = pair_r;
      fault_nxt = fault_r;
      rsv14_nxt = rsv14_r;
      rsv_nxt   = rsv_r;
      if (run_r && CABLE_TEST_DONE) begin
         run_nxt   = 1'b0;
         fault_nxt = CABLE_TEST_FAULT;
      end
      // A write in the done cycle wins: a new start restarts the test
      if (wr_diag) begin
         run_nxt   = WR_DATA[DIAG_START_BIT];
         pair_nxt  = WR_DATA[DIAG_PAIR_HI:DIAG_PAIR_LO];
         rsv14_nxt = WR_DATA[DIAG_RSV14_BIT];
         rsv_nxt   = WR_DATA[DIAG_RSV_HI:DIAG_RSV_LO];
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         run_r   <= RST_CABLE_DIAG[DIAG_START_BIT];
         pair_r  <= RST_CABLE_DIAG[DIAG_PAIR_HI:DIAG_PAIR_LO];
         fault_r <= RST_CABLE_DIAG[DIAG_FAULT_HI:DIAG_FAULT_LO];
         rsv14_r <= RST_CABLE_DIAG[DIAG_RSV14_BIT];
         rsv_r   <= RST_CABLE_DIAG[DIAG_RSV_HI:DIAG_RSV_LO];
      end else begin
         run_r   <= run_nxt;
         pair_r  <= pair_nxt;
         fault_r <= fault_nxt;
         rsv14_r <= rsv14_nxt;
         rsv_r   <= rsv_nxt;
      end
   end

   assign CABLE_TEST_RUN  = run_r;
   assign CABLE_TEST_PAIR = pair_r;

   ////////////////////////////////////////////////////////////////////////////
   // Symbol error frame counter

   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (rd_cnt) begin
         cnt_nxt = 16'h0000;
      end
      // A frame in the read cycle is kept as the first of the new count
      if (RX_SYM_ERR_FRAME) begin
         cnt_nxt = rd_cnt ? 16'h0001 : sat_inc(cnt_r);
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cnt_r <= RST_RX_SYM_CNT;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event flags and enables

   logic [7:0] ev_flags;
   logic [7:0] ev_en;
   logic       irq_w;

   pder_event_flags #(
      .N       (EVENT_N)
   ) u_events (
      .clk     (REF_CLK),
      .rst     (SYS_RST),
      .en_wr   (wr_event),
      .en_data (WR_DATA[15:8]),
      .rd_clr  (rd_event),
      .ev_in   (PHY_EVENT),
      .flags   (ev_flags),
      .enables (ev_en),
      .irq     (irq_w)
   );

   assign PHY_IRQ = irq_w;

   ////////////////////////////////////////////////////////////////////////////
   // Crossover control

   logic [15:0] xover_r;
   logic [15:0] xover_nxt;
   logic        xauto_r;
   logic        xauto_nxt;
   logic        xmdi_r;
   logic        xmdi_nxt;

   always_comb begin
      xover_nxt = wr_xover ? WR_DATA : xover_r;
      xauto_nxt = !xover_nxt[XOVER_DIS_BIT];
      // Force bit is masked while automatic selection owns the pins
      xmdi_nxt  = xover_nxt[XOVER_DIS_BIT] && xover_nxt[XOVER_FORCE_BIT];
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         xover_r <= RST_CROSSOVER;
         xauto_r <= !RST_CROSSOVER[XOVER_DIS_BIT];
         xmdi_r  <= RST_CROSSOVER[XOVER_DIS_BIT] && RST_CROSSOVER[XOVER_FORCE_BIT];
      end else begin
         xover_r <= xover_nxt;
         xauto_r <= xauto_nxt;
         xmdi_r  <= xmdi_nxt;
      end
   end

   assign XOVER_AUTO = xauto_r;
   assign XOVER_MDI  = xmdi_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   logic [15:0] rd_r;
   logic [15:0] rd_nxt;

   always_comb begin
      rd_nxt = 16'h0000;
      if (RD_EN) begin
         if (hit(ADDR, OFS_CABLE_DIAG_CONTROL)) begin
            rd_nxt = {run_r, rsv14_r, pair_r, rsv_r, fault_r, 8'h00};
         end else if (hit(ADDR, OFS_PMA_PCS_LINK_STATUS)) begin
            rd_nxt = {14'h0000, LINK_1000_UP, LINK_100_UP};
         end else if (rd_cnt) begin
            rd_nxt = cnt_r;
         end else if (rd_event) begin
            rd_nxt = {ev_en, ev_flags};
         end else if (hit(ADDR, OFS_CROSSOVER_CONTROL)) begin
            rd_nxt = xover_r;
         end
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rd_r <= 16'h0000;
      end else begin
         rd_r <= rd_nxt;
      end
   end

   assign RD_DATA = rd_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_diag_start;
      wr_diag && WR_DATA[DIAG_START_BIT];
   endsequence

   sequence s_diag_end;
      run_r && CABLE_TEST_DONE && !wr_diag;
   endsequence

   sequence s_run_idle;
      !run_r && !wr_diag;
   endsequence

   sequence s_cnt_read_frame;
      rd_cnt && RX_SYM_ERR_FRAME;
   endsequence

   a_diag_start: assert property (s_diag_start |=> CABLE_TEST_RUN)
      else $error("test not started by write of one");
   a_diag_stop: assert property (wr_diag && !WR_DATA[DIAG_START_BIT] |=> !CABLE_TEST_RUN)
      else $error("test not stopped by write of zero");
   a_diag_selfclr: assert property (s_diag_end |=> !CABLE_TEST_RUN)
      else $error("start bit not self cleared");
   a_diag_hold: assert property (s_diag_start ##1 (!CABLE_TEST_DONE && !wr_diag)
         |=> CABLE_TEST_RUN)
      else $error("test ended without done");
   a_diag_no_restart: assert property (s_run_idle |=> !CABLE_TEST_RUN)
      else $error("test started without a write");
   a_diag_readback: assert property (RD_EN && hit(ADDR, OFS_CABLE_DIAG_CONTROL)
         |=> RD_DATA[DIAG_START_BIT] == $past(run_r)
             && RD_DATA[DIAG_FAULT_HI:DIAG_FAULT_LO] == $past(fault_r))
      else $error("diagnostic readback wrong");
   a_pair_select: assert property (wr_diag |=> CABLE_TEST_PAIR == $past(WR_DATA[13:12]))
      else $error("pair select not taken");
   a_pair_hold: assert property (!wr_diag |=> $stable(CABLE_TEST_PAIR))
      else $error("pair changed without a write");
   a_fault_capture: assert property (s_diag_end
         ##1 RD_EN && hit(ADDR, OFS_CABLE_DIAG_CONTROL)
         |=> RD_DATA[9:8] == $past(CABLE_TEST_FAULT, 2))
      else $error("fault code not reported");
   a_fault_take: assert property (run_r && CABLE_TEST_DONE
         |=> fault_r == $past(CABLE_TEST_FAULT))
      else $error("fault code not captured at done");
   a_fault_hold: assert property (!(run_r && CABLE_TEST_DONE)
         |=> fault_r == $past(fault_r))
      else $error("fault code changed without done");
   a_link_read: assert property (RD_EN && hit(ADDR, OFS_PMA_PCS_LINK_STATUS)
         |=> RD_DATA == {14'h0000, $past(LINK_1000_UP), $past(LINK_100_UP)})
      else $error("link status readback wrong");
   a_cnt_clear: assert property (rd_cnt && !RX_SYM_ERR_FRAME |=> cnt_r == 16'h0000)
      else $error("counter not cleared by read");
   a_cnt_restart: assert property (s_cnt_read_frame |=> cnt_r == 16'h0001)
      else $error("frame in read cycle lost");
   a_cnt_step: assert property (!rd_cnt && RX_SYM_ERR_FRAME && cnt_r != 16'hffff
         |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not step");
   a_cnt_saturate: assert property (!rd_cnt && RX_SYM_ERR_FRAME && cnt_r == 16'hffff
         |=> cnt_r == 16'hffff)
      else $error("counter wrapped");
   a_cnt_hold: assert property (!rd_cnt && !RX_SYM_ERR_FRAME |=> $stable(cnt_r))
      else $error("counter moved without a frame");
   a_cnt_readout: assert property (rd_cnt |=> RD_DATA == $past(cnt_r))
      else $error("counter readback wrong");
   a_event_readout: assert property (rd_event
         |=> RD_DATA == {$past(ev_en), $past(ev_flags)})
      else $error("event register readback wrong");
   a_xover_auto: assert property (wr_xover |=> XOVER_AUTO == !$past(WR_DATA[6]))
      else $error("auto crossover not set by disable bit");
   a_xover_force: assert property (XOVER_AUTO |-> !XOVER_MDI)
      else $error("force bit acted while auto enabled");
   a_xover_mdi: assert property (wr_xover
         |=> XOVER_MDI == ($past(WR_DATA[XOVER_DIS_BIT]) && $past(WR_DATA[XOVER_FORCE_BIT])))
      else $error("forced crossover not taken");
   a_xover_hold: assert property (!wr_xover
         |=> $stable(XOVER_AUTO) && $stable(XOVER_MDI))
      else $error("crossover changed without a write");
   a_xover_read: assert property (RD_EN && hit(ADDR, OFS_CROSSOVER_CONTROL)
         |=> RD_DATA == $past(xover_r))
      else $error("crossover readback wrong");
   a_rd_only_once: assert property (!RD_EN |=> RD_DATA == 16'h0000)
      else $error("read data outside its cycle");

endmodule

//--- rtl/pder_pkg.sv
package pder_pkg;

   // Register bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // Register offsets within one port's window
   localparam logic [11:0] OFS_CABLE_DIAG_CONTROL      = 12'h124;
   localparam logic [11:0] OFS_PMA_PCS_LINK_STATUS     = 12'h126;
   localparam logic [11:0] OFS_RX_SYMBOL_ERROR_COUNT   = 12'h12a;
   localparam logic [11:0] OFS_PHY_EVENT_CONTROL_STATUS = 12'h136;
   localparam logic [11:0] OFS_CROSSOVER_CONTROL       = 12'h138;

   // cable_diag_control fields
   localparam int DIAG_START_BIT = 15;
   localparam int DIAG_RSV14_BIT = 14;
   localparam int DIAG_PAIR_HI   = 13;
   localparam int DIAG_PAIR_LO   = 12;
   localparam int DIAG_RSV_HI    = 11;
   localparam int DIAG_RSV_LO    = 10;
   localparam int DIAG_FAULT_HI  = 9;
   localparam int DIAG_FAULT_LO  = 8;

   // Pair and fault encodings
   localparam logic [1:0] PAIR_A      = 2'h0;
   localparam logic [1:0] PAIR_B      = 2'h1;
   localparam logic [1:0] PAIR_C      = 2'h2;
   localparam logic [1:0] PAIR_D      = 2'h3;
   localparam logic [1:0] FAULT_NONE  = 2'h0;
   localparam logic [1:0] FAULT_OPEN  = 2'h1;
   localparam logic [1:0] FAULT_SHORT = 2'h2;

   // pma_pcs_link_status fields
   localparam int LINK_1000_BIT = 1;
   localparam int LINK_100_BIT  = 0;

   // phy_event_control_status layout: enables high byte, flags low byte
   localparam int EVENT_N     = 8;
   localparam int EV_JABBER   = 7;
   localparam int EV_RX_ERR   = 6;
   localparam int EV_PAGE_RX  = 5;
   localparam int EV_PD_FAULT = 4;
   localparam int EV_LP_ACK   = 3;
   localparam int EV_LINK_DN  = 2;
   localparam int EV_REM_FLT  = 1;
   localparam int EV_LINK_UP  = 0;

   // crossover_control fields
   localparam int XOVER_FORCE_BIT = 7;
   localparam int XOVER_DIS_BIT   = 6;

   // Reset values
   localparam logic [15:0] RST_CABLE_DIAG = 16'h0000;
   localparam logic [15:0] RST_RX_SYM_CNT = 16'h0000;
   localparam logic [7:0]  RST_EVENT_EN   = 8'h00;
   localparam logic [7:0]  RST_EVENT_FLAG = 8'h00;
   localparam logic [15:0] RST_CROSSOVER  = 16'h0000;

endpackage

//--- rtl/pder_event_flags.sv
`timescale 1ns/1ps

module pder_event_flags
   import pder_pkg::*;
#(
   parameter int N = EVENT_N
) (
   input  wire logic         clk,      // Core clock
   input  wire logic         rst,      // Async reset, high
   input  wire logic         en_wr,    // Write of enable byte
   input  wire logic [N-1:0] en_data,  // New enable bits
   input  wire logic         rd_clr,   // Status read, clears flags
   input  wire logic [N-1:0] ev_in,    // Event pulses
   output logic      [N-1:0] flags,    // Sticky flags
   output logic      [N-1:0] enables,  // Enable bits
   output logic              irq       // Gated request
);

   logic [N-1:0] en_r;
   logic [N-1:0] en_nxt;
   logic [N-1:0] flag_r;
   logic [N-1:0] flag_nxt;
   logic         irq_r;
   logic         irq_nxt;

   always_comb begin
      en_nxt   = en_wr ? en_data : en_r;
      // New event beats the read clear so none is lost
      flag_nxt = (rd_clr ? '0 : flag_r) | ev_in;
      irq_nxt  = |(flag_nxt & en_nxt);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_r   <= RST_EVENT_EN;
         flag_r <= RST_EVENT_FLAG;
         irq_r  <= 1'b0;
      end else begin
         en_r   <= en_nxt;
         flag_r <= flag_nxt;
         irq_r  <= irq_nxt;
      end
   end

   assign flags   = flag_r;
   assign enables = en_r;
   assign irq     = irq_r;

   ////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_enable_write: assert property (en_wr |=> enables == $past(en_data))
      else $error("enable byte not taken from write");
   a_flag_clear: assert property (rd_clr && ev_in == '0 |=> flags == '0)
      else $error("flags not cleared by read");
   a_flag_sticky: assert property (!rd_clr
         |=> (flags & $past(flags | ev_in)) == $past(flags | ev_in))
      else $error("flag lost without read");
   a_irq_gate: assert property (irq == |(flags & enables))
      else $error("request does not match flags and enables");

endmodule

//--- verification/pder_phy_diag_event_regs_bench.sv
`timescale 1ns/1ps

module pder_phy_diag_event_regs_bench
   import pder_pkg::*;
;
   // Whole run needs well under a thousand cycles
   localparam int LIMIT = 5000;

   logic        REF_CLK;
   logic        SYS_RST;
   logic [11:0] ADDR;
   logic [15:0] WR_DATA;
   logic        WR_EN;
   logic        RD_EN;
   logic [15:0] RD_DATA;
   logic        CABLE_TEST_RUN;
   logic [1:0]  CABLE_TEST_PAIR;
   logic        CABLE_TEST_DONE;
   logic [1:0]  CABLE_TEST_FAULT;
   logic        LINK_1000_UP;
   logic        LINK_100_UP;
   logic        RX_SYM_ERR_FRAME;
   logic [7:0]  PHY_EVENT;
   logic        PHY_IRQ;
   logic        XOVER_AUTO;
   logic        XOVER_MDI;
   int          fails;
   int          checked;
   int          cyc;
   int          n;
   logic [15:0] rnd;
   logic [15:0] v;
   logic [7:0]  en;
   logic [7:0]  ev;
   logic [1:0]  flt;

   pder_phy_diag_event_regs DUT (
      .REF_CLK          (REF_CLK),
      .SYS_RST          (SYS_RST),
      .ADDR             (ADDR),
      .WR_DATA          (WR_DATA),
      .WR_EN            (WR_EN),
      .RD_EN            (RD_EN),
      .RD_DATA          (RD_DATA),
      .CABLE_TEST_RUN   (CABLE_TEST_RUN),
      .CABLE_TEST_PAIR  (CABLE_TEST_PAIR),
      .CABLE_TEST_DONE  (CABLE_TEST_DONE),
      .CABLE_TEST_FAULT (CABLE_TEST_FAULT),
      .LINK_1000_UP     (LINK_1000_UP),
      .LINK_100_UP      (LINK_100_UP),
      .RX_SYM_ERR_FRAME (RX_SYM_ERR_FRAME),
      .PHY_EVENT        (PHY_EVENT),
      .PHY_IRQ          (PHY_IRQ),
      .XOVER_AUTO       (XOVER_AUTO),
      .XOVER_MDI        (XOVER_MDI)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [15:0] exp_diag(input logic r, input logic [1:0] p,
                                            input logic [1:0] f);
      return {r, 1'b0, p, 2'b00, f, 8'h00};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge REF_CLK);
      ADDR    <= a;
      WR_DATA <= d;
      WR_EN   <= 1'b1;
      @(posedge REF_CLK);
      WR_EN   <= 1'b0;
      WR_DATA <= ~d;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge REF_CLK);
      ADDR  <= a;
      RD_EN <= 1'b1;
      @(posedge REF_CLK);
      RD_EN <= 1'b0;
      #1;
      d = RD_DATA;
   endtask

   task automatic done_pulse(input logic [1:0] f);
      @(posedge REF_CLK);
      CABLE_TEST_DONE  <= 1'b1;
      CABLE_TEST_FAULT <= f;
      @(posedge REF_CLK);
      CABLE_TEST_DONE  <= 1'b0;
      CABLE_TEST_FAULT <= ~f;
      #1;
   endtask

   task automatic summarize();
      if (fails == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   always @(posedge REF_CLK) begin
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         summarize();
      end
   end

   initial begin
      fails            = 0;
      checked          = 0;
      cyc              = 0;
      rnd              = 16'he317;
      flt              = 2'b00;
      SYS_RST          = 1'b1;
      ADDR             = 12'h000;
      WR_DATA          = 16'h0000;
      WR_EN            = 1'b0;
      RD_EN            = 1'b0;
      CABLE_TEST_DONE  = 1'b0;
      CABLE_TEST_FAULT = 2'b00;
      LINK_1000_UP     = 1'b1;
      LINK_100_UP      = 1'b0;
      RX_SYM_ERR_FRAME = 1'b0;
      PHY_EVENT        = 8'h00;
      repeat (2) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      chk(16'(XOVER_AUTO), 16'h0001);
      chk({14'h0, CABLE_TEST_RUN, PHY_IRQ}, 16'h0000);
      rd(OFS_CABLE_DIAG_CONTROL, v);
      chk(v, 16'h0000);
      rd(OFS_RX_SYMBOL_ERROR_COUNT, v);
      chk(v, 16'h0000);
      rd(OFS_PHY_EVENT_CONTROL_STATUS, v);
      chk(v, 16'h0000);
      rd(OFS_CROSSOVER_CONTROL, v);
      chk(v, 16'h0000);
      // Unmapped place takes no write and reads zero
      wr(12'h130, 16'hffff);
      rd(12'h130, v);
      chk(v, 16'h0000);
      // Every pair, faults none/open/short, back-to-back with reads
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CABLE_DIAG_CONTROL, exp_diag(1'b1, 2'(p), 2'b00));
         chk(16'(CABLE_TEST_RUN), 16'h0001);
         chk(16'(CABLE_TEST_PAIR), 16'(p));
         rd(OFS_CABLE_DIAG_CONTROL, v);
         chk(v, exp_diag(1'b1, 2'(p), flt));
         flt = 2'(p % 3);
         done_pulse(flt);
         chk(16'(CABLE_TEST_RUN), 16'h0000);
         rd(OFS_CABLE_DIAG_CONTROL, v);
         chk(v, exp_diag(1'b0, 2'(p), flt));
      end
      // Abort by writing zero, then a stray completion is ignored
      wr(OFS_CABLE_DIAG_CONTROL, 16'hb000);
      wr(OFS_CABLE_DIAG_CONTROL, 16'h3000);
      chk(16'(CABLE_TEST_RUN), 16'h0000);
      done_pulse(2'b11);
      rd(OFS_CABLE_DIAG_CONTROL, v);
      chk(v, exp_diag(1'b0, 2'b11, flt));
      // Link states are live
      for (int i = 0; i < 4; i++) begin
         @(posedge REF_CLK);
         LINK_1000_UP <= i[1];
         LINK_100_UP  <= i[0];
         rd(OFS_PMA_PCS_LINK_STATUS, v);
         chk(v, 16'(i));
      end
      // Symbol error frames, then clear on read
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         n = 1 + int'(rnd[4:0]);
         repeat (n) begin
            @(posedge REF_CLK);
            RX_SYM_ERR_FRAME <= 1'b1;
         end
         @(posedge REF_CLK);
         RX_SYM_ERR_FRAME <= 1'b0;
         rd(OFS_RX_SYMBOL_ERROR_COUNT, v);
         chk(v, 16'(n));
         rd(OFS_RX_SYMBOL_ERROR_COUNT, v);
         chk(v, 16'h0000);
      end
      // Each event alone, then random mixes; low byte of a write is dropped
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         en = rnd[15:8];
         ev = (i < 8) ? 8'(1 << i) : rnd[7:0];
         wr(OFS_PHY_EVENT_CONTROL_STATUS, rnd);
         @(posedge REF_CLK);
         PHY_EVENT <= ev;
         @(posedge REF_CLK);
         PHY_EVENT <= 8'h00;
         #1;
         chk(16'(PHY_IRQ), 16'(|(en & ev)));
         rd(OFS_PHY_EVENT_CONTROL_STATUS, v);
         chk(v, {en, ev});
         chk(16'(PHY_IRQ), 16'h0000);
         rd(OFS_PHY_EVENT_CONTROL_STATUS, v);
         chk(v, {en, 8'h00});
      end
      // Crossover modes with random reserved bits
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         v = (rnd & 16'hff3f) | {8'h00, 2'(i), 6'h00};
         wr(OFS_CROSSOVER_CONTROL, v);
         chk(16'(XOVER_AUTO), 16'(!v[6]));
         chk(16'(XOVER_MDI), 16'(v[6] & v[7]));
         rd(OFS_CROSSOVER_CONTROL, rnd);
         chk(rnd, v);
      end
      summarize();
   end

endmodule
